// ### mids_top.sv
// mids_top: input detection setup for a brushless motor controller, with an
// Avalon-MM register slave and a capture event generator.
// assumes: single clock clk_sys at 50 MHz, synchronous active-high reset,
// motor inputs already synchronous to clk_sys.
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.

module mids_top #(
  parameter int EVENT_WIDTH = 16
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        motor_input_a,
  input  wire logic        motor_input_b,
  input  wire logic        motor_input_c,
  output logic      [5:0]  pin_roles,
  output logic      [2:0]  pin_reserved,
  output logic      [2:0]  pin_ground_oe,
  output logic             comparator_on,
  output logic             capture_event
);

  mids_cfg_if cfg ();

  logic [7:0]             config_reg;
  logic                   done;
  mids_pkg::mids_mode_t   next_mode;
  mids_pkg::mids_mode_t   mode;
  logic [5:0]             next_roles;
  logic [2:0]             next_reserved;
  logic                   next_comp;
  logic [2:0]             inputs;
  logic [2:0]             inputs_d;
  logic                   prev_sel;
  logic                   cur_sel;
  logic                   next_event;
  logic [EVENT_WIDTH-1:0] event_count;

  assign inputs = {motor_input_c, motor_input_b, motor_input_a};

  // config fields into the carrier
  assign cfg.input_select_field         = config_reg[mids_pkg::CFG_INPUT_SEL_LSB +: 2];
  assign cfg.edge_select_field          = config_reg[mids_pkg::CFG_EDGE_SEL_LSB +: 2];
  assign cfg.sensor_mode_bit            = config_reg[mids_pkg::CFG_SENSOR_BIT];
  assign cfg.pin_config_bit             = config_reg[mids_pkg::CFG_PIN_CFG_BIT];
  assign cfg.off_state_discharge_select = config_reg[mids_pkg::CFG_DISCHARGE_BIT];
  assign cfg.comp_off_request           = config_reg[mids_pkg::CFG_COMP_OFF_BIT];

  mids_decode u_decode (
    .cfg           (cfg),
    .mode          (next_mode),
    .pin_roles     (next_roles),
    .pin_reserved  (next_reserved),
    .comparator_on (next_comp)
  );

  // bus handshake: waitrequest rests high, drops for the second request cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // transfer accepted in the cycle that waitrequest is low
  always_comb begin
    done = !avs_waitrequest;
  end

  // config register write; input select applies immediately (direct load)
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      config_reg <= mids_pkg::CFG_RESET;
    end else if (avs_write && done && avs_address == mids_pkg::ADDR_CONFIG
                 && avs_byteenable[0]) begin
      config_reg <= avs_writedata[7:0];
    end
  end

  // read data
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !done) begin
      case (avs_address)
        mids_pkg::ADDR_CONFIG: avs_readdata <= {24'h00_0000, config_reg};
        mids_pkg::ADDR_STATUS: avs_readdata <= {14'h0000, comparator_on,
                                                pin_reserved, pin_roles, 3'h0, mode};
        mids_pkg::ADDR_EVENT:  avs_readdata <= {{(32-EVENT_WIDTH){1'b0}}, event_count};
        default:               avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // registered decode outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode          <= mids_pkg::MIDS_MODE_SENSORLESS;
      pin_roles     <= 6'h00;
      pin_reserved  <= 3'h0;
      pin_ground_oe <= 3'h0;
      comparator_on <= 1'b0;
    end else begin
      mode          <= next_mode;
      pin_roles     <= next_roles;
      pin_reserved  <= next_reserved;
      comparator_on <= next_comp;
      for (int i = 0; i < 3; i++) begin
        pin_ground_oe[i] <= (next_roles[i*2 +: 2] == mids_pkg::ROLE_GROUND);
      end
    end
  end

  // edge detection history
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      inputs_d <= 3'h0;
    end else begin
      inputs_d <= inputs;
    end
  end

  always_comb begin
    // select 11 has no tacho pin; keeps the index in range while mode lags
    cur_sel  = (cfg.input_select_field == mids_pkg::SEL_ENCODER) ? 1'b0
                                                                 : inputs[cfg.input_select_field];
    prev_sel = (cfg.input_select_field == mids_pkg::SEL_ENCODER) ? 1'b0
                                                                 : inputs_d[cfg.input_select_field];
    next_event = 1'b0;
    if (mode == mids_pkg::MIDS_MODE_TACHO) begin
      case (cfg.edge_select_field)
        mids_pkg::EDGE_RISE: next_event = cur_sel && !prev_sel;
        mids_pkg::EDGE_FALL: next_event = !cur_sel && prev_sel;
        mids_pkg::EDGE_BOTH: next_event = cur_sel != prev_sel;
        default:             next_event = 1'b0;
      endcase
    end else if (mode == mids_pkg::MIDS_MODE_ENCODER) begin
      next_event = inputs[1:0] != inputs_d[1:0];
    end
  end

  // capture event pulse and count
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      capture_event <= 1'b0;
      event_count   <= '0;
    end else begin
      capture_event <= next_event;
      if (next_event) begin
        event_count <= event_count + 1'b1;
      end
    end
  end

  a_bus_wait: assert property (@(posedge clk_sys) disable iff (reset)
    (avs_read || avs_write) && !done |=> !avs_waitrequest)
    else $error("bus answer late");

  a_sensorless_roles: assert property (@(posedge clk_sys) disable iff (reset)
    (!cfg.pin_config_bit && cfg.edge_select_field == 2'h0 && !cfg.sensor_mode_bit
     && cfg.input_select_field == 2'h1) |=> (pin_roles[3:2] == 2'h2 && pin_reserved == 3'h7))
    else $error("sensorless pin roles wrong");

  a_discharge_sel: assert property (@(posedge clk_sys) disable iff (reset)
    (!cfg.pin_config_bit && cfg.edge_select_field == 2'h0 && !cfg.sensor_mode_bit
     && cfg.input_select_field == 2'h0 && cfg.off_state_discharge_select)
    |=> pin_ground_oe == 3'h6)
    else $error("off pins not grounded");

  a_position_roles: assert property (@(posedge clk_sys) disable iff (reset)
    (!cfg.pin_config_bit && cfg.edge_select_field == 2'h0 && cfg.sensor_mode_bit
     && cfg.input_select_field == 2'h2) |=> pin_roles == 6'h30)
    else $error("position pin roles wrong");

  a_comp_on: assert property (@(posedge clk_sys) disable iff (reset)
    (cfg.pin_config_bit && cfg.edge_select_field == 2'h0
     && cfg.input_select_field != 2'h3) |=> comparator_on)
    else $error("comparator not on");

  a_pins_free: assert property (@(posedge clk_sys) disable iff (reset)
    (cfg.pin_config_bit && cfg.input_select_field == 2'h3 && cfg.edge_select_field == 2'h0)
    |=> pin_reserved == 3'h0)
    else $error("pins not released");

  a_comp_off: assert property (@(posedge clk_sys) disable iff (reset)
    (cfg.pin_config_bit && cfg.edge_select_field != 2'h0 && cfg.input_select_field == 2'h3
     && cfg.comp_off_request) |=> (!comparator_on && pin_reserved == 3'h0))
    else $error("comparator not off");

  a_encoder_pins: assert property (@(posedge clk_sys) disable iff (reset)
    (cfg.pin_config_bit && cfg.edge_select_field != 2'h0 && cfg.input_select_field == 2'h3
     && !cfg.comp_off_request) |=> pin_roles == 6'h0F)
    else $error("encoder pin roles wrong");

  a_tacho_rise: assert property (@(posedge clk_sys) disable iff (reset)
    (mode == mids_pkg::MIDS_MODE_TACHO && cfg.edge_select_field == 2'h1
     && $rose(inputs[cfg.input_select_field])) |=> capture_event)
    else $error("rising edge missed");

  a_encoder_edges: assert property (@(posedge clk_sys) disable iff (reset)
    (mode == mids_pkg::MIDS_MODE_ENCODER && $changed(inputs[0])) |=> capture_event)
    else $error("encoder edge missed");

endmodule : mids_top

// ### mids_pkg.sv
// mids_pkg: register offsets, field positions, reset values and modes for the
// motor input detection setup block.
// assumes: a single 50 MHz system clock, Avalon-MM register access.
package mids_pkg;

  // register word byte addresses
  localparam logic [3:0] ADDR_CONFIG = 4'h0;  // selection bits
  localparam logic [3:0] ADDR_STATUS = 4'h4;  // decoded mode and pin roles
  localparam logic [3:0] ADDR_EVENT  = 4'h8;  // capture event counter

  // config field positions
  localparam int CFG_INPUT_SEL_LSB = 0;   // input_select_field [1:0]
  localparam int CFG_EDGE_SEL_LSB  = 2;   // edge_select_field [3:2]
  localparam int CFG_SENSOR_BIT    = 4;   // sensor_mode_bit
  localparam int CFG_PIN_CFG_BIT   = 5;   // pin_config_bit
  localparam int CFG_DISCHARGE_BIT = 6;   // off_state_discharge_select
  localparam int CFG_COMP_OFF_BIT  = 7;   // software request: comparator off
  localparam int CFG_WIDTH         = 8;

  localparam logic [7:0] CFG_RESET = 8'h00;

  // field encodings
  localparam logic [1:0] SEL_A       = 2'h0;
  localparam logic [1:0] SEL_B       = 2'h1;
  localparam logic [1:0] SEL_C       = 2'h2;
  localparam logic [1:0] SEL_ENCODER = 2'h3;
  localparam logic [1:0] EDGE_NONE   = 2'h0;
  localparam logic [1:0] EDGE_RISE   = 2'h1;
  localparam logic [1:0] EDGE_FALL   = 2'h2;
  localparam logic [1:0] EDGE_BOTH   = 2'h3;

  // pin role codes, two bits per pin
  localparam logic [1:0] ROLE_HIZ     = 2'h0;  // off, high impedance
  localparam logic [1:0] ROLE_GROUND  = 2'h1;  // off, pulled to ground
  localparam logic [1:0] ROLE_ANALOG  = 2'h2;  // analog input
  localparam logic [1:0] ROLE_DIGITAL = 2'h3;  // digital input
  localparam logic [1:0] ROLE_STD_IO  = 2'h0;  // released; driven as std I/O

  // detection modes, one-hot
  typedef enum logic [4:0] {
    MIDS_MODE_SENSORLESS = 5'h01,
    MIDS_MODE_POSITION   = 5'h02,
    MIDS_MODE_TACHO      = 5'h04,
    MIDS_MODE_ENCODER    = 5'h08,
    MIDS_MODE_INVALID    = 5'h10
  } mids_mode_t;

endpackage : mids_pkg

// ### mids_cfg_if.sv
// mids_cfg_if: carries the stored selection bits from the register slave
// to the mode decoder.
// assumes: both ends on clk_sys.
interface mids_cfg_if;
  logic [1:0] input_select_field;
  logic [1:0] edge_select_field;
  logic       sensor_mode_bit;
  logic       pin_config_bit;
  logic       off_state_discharge_select;
  logic       comp_off_request;

  modport source (output input_select_field, output edge_select_field,
                  output sensor_mode_bit, output pin_config_bit,
                  output off_state_discharge_select, output comp_off_request);
  modport sink   (input input_select_field, input edge_select_field,
                  input sensor_mode_bit, input pin_config_bit,
                  input off_state_discharge_select, input comp_off_request);
endinterface : mids_cfg_if

// ### mids_decode.sv
// mids_decode: combinational decode of mode, pin roles and comparator enable
// from the selection bits.
// assumes: inputs stable per clk_sys cycle; outputs registered by the caller.
module mids_decode (
  mids_cfg_if.sink             cfg,
  output mids_pkg::mids_mode_t mode,
  output logic [5:0]           pin_roles,
  output logic [2:0]           pin_reserved,
  output logic                 comparator_on
);

  logic [1:0] off_role;
  logic [1:0] sel;

  assign off_role = cfg.off_state_discharge_select ? mids_pkg::ROLE_GROUND
                                                   : mids_pkg::ROLE_HIZ;
  assign sel = cfg.input_select_field;

  // mode and pin role table
  always_comb begin
    mode          = mids_pkg::MIDS_MODE_INVALID;
    pin_roles     = {3{mids_pkg::ROLE_STD_IO}};
    pin_reserved  = 3'h0;
    comparator_on = 1'b0;
    if (cfg.edge_select_field == mids_pkg::EDGE_NONE) begin
      mode = cfg.sensor_mode_bit ? mids_pkg::MIDS_MODE_POSITION
                                 : mids_pkg::MIDS_MODE_SENSORLESS;
      if (!cfg.pin_config_bit && sel != mids_pkg::SEL_ENCODER) begin
        if (!cfg.sensor_mode_bit) begin
          pin_roles     = {3{off_role}};
          pin_roles[sel*2 +: 2] = mids_pkg::ROLE_ANALOG;
          pin_reserved  = 3'h7;
          comparator_on = 1'b1;
        end else begin
          pin_roles[sel*2 +: 2] = mids_pkg::ROLE_DIGITAL;
          pin_reserved[sel]     = 1'b1;
          comparator_on         = 1'b1;
        end
      end else if (cfg.pin_config_bit) begin
        if (sel != mids_pkg::SEL_ENCODER) begin
          pin_roles[sel*2 +: 2] = mids_pkg::ROLE_ANALOG;
          pin_reserved[sel]     = 1'b1;
          comparator_on         = 1'b1;
        end else begin
          comparator_on = !cfg.comp_off_request;
        end
      end else begin
        mode = mids_pkg::MIDS_MODE_INVALID;
      end
    end else begin
      mode = (sel == mids_pkg::SEL_ENCODER) ? mids_pkg::MIDS_MODE_ENCODER
                                             : mids_pkg::MIDS_MODE_TACHO;
      if (cfg.pin_config_bit) begin
        if (sel == mids_pkg::SEL_ENCODER && cfg.comp_off_request) begin
          comparator_on = 1'b0;
        end else if (sel == mids_pkg::SEL_ENCODER) begin
          pin_roles    = {mids_pkg::ROLE_STD_IO, mids_pkg::ROLE_DIGITAL,
                          mids_pkg::ROLE_DIGITAL};
          pin_reserved = 3'h3;
        end else begin
          pin_roles[sel*2 +: 2] = mids_pkg::ROLE_DIGITAL;
          pin_reserved[sel]     = 1'b1;
        end
      end else begin
        mode = mids_pkg::MIDS_MODE_INVALID;
      end
    end
  end

endmodule : mids_decode

// ### mids_sensor_model.sv
// mids_sensor_model: hall, tacho or encoder sensors on the three motor inputs.
// assumes: levels change just after a clk_sys edge, like a synchronised sensor.
module mids_sensor_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [2:0] level_req,
  input  wire logic       slow,
  output logic            motor_input_a,
  output logic            motor_input_b,
  output logic            motor_input_c
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] stage;

  // a slow sensor answers one cycle later than a prompt one
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage <= 3'h0;
      {motor_input_c, motor_input_b, motor_input_a} <= 3'h0;
    end else begin
      stage <= level_req;
      {motor_input_c, motor_input_b, motor_input_a} <= slow ? stage : level_req;
    end
  end
endmodule : mids_sensor_model

// ### tb_mids_top.sv
// tb_mids_top: self-checking bench for the input detection setup block.
// assumes: mids_pkg, mids_cfg_if, mids_decode and mids_top compiled first.
module tb_mids_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        motor_input_a;
  logic        motor_input_b;
  logic        motor_input_c;
  logic [5:0]  pin_roles;
  logic [2:0]  pin_reserved;
  logic [2:0]  pin_ground_oe;
  logic        comparator_on;
  logic        capture_event;
  logic [2:0]  level_req = 3'h0;
  logic        slow = 1'b0;
  logic [31:0] rd;
  logic [7:0]  cfg;
  logic [7:0]  prev;
  int          failures = 0;
  int          checks_done = 0;
  int          pulses = 0;

  // 50 MHz clock and a running count of capture pulses
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (capture_event === 1'b1) pulses <= pulses + 1;
  end

  mids_top #(.EVENT_WIDTH(16)) i_mids_top (
    .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .motor_input_a(motor_input_a), .motor_input_b(motor_input_b),
    .motor_input_c(motor_input_c), .pin_roles(pin_roles), .pin_reserved(pin_reserved),
    .pin_ground_oe(pin_ground_oe), .comparator_on(comparator_on),
    .capture_event(capture_event));

  mids_sensor_model i_mids_sensor_model (
    .clk_sys(clk_sys), .reset(reset), .level_req(level_req), .slow(slow),
    .motor_input_a(motor_input_a), .motor_input_b(motor_input_b),
    .motor_input_c(motor_input_c));

  task automatic end_of_test;
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] dat,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= dat;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      end_of_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr_reg(input logic [3:0] adr, input logic [31:0] dat, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, adr, dat, be, q);
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] adr, output logic [31:0] q);
    bus(1'b0, adr, 32'h0, 4'hF, q);
  endtask : rd_reg

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_cycles

  // expected mode, roles, reserved and comparator for one legal setting
  task automatic chk_cfg(input logic [7:0] c);
    logic [1:0]  s;
    logic [17:0] ex;
    logic [17:0] mk;
    logic [5:0]  ro;
    logic [2:0]  gr;
    s = c[1:0];
    ex = 18'h0;
    mk = 18'h1FF1F;
    ro = 6'h00;
    gr = 3'h0;
    if (c[3:2] == 2'h0) begin
      ex[4:0] = c[4] ? 5'h02 : 5'h01;
    end else begin
      ex[4:0] = (s == 2'h3) ? 5'h08 : 5'h04;
    end
    if (!c[5]) begin
      for (int p = 0; p < 3; p++) begin
        if (!c[4] && p != s) ro[2*p +: 2] = c[6] ? 2'h1 : 2'h0;
        if (!c[4] && p != s) gr[p] = c[6];
      end
      ro[2*s +: 2] = c[4] ? 2'h3 : 2'h2;
    end else if (c[3:2] == 2'h0) begin
      if (s != 2'h3) ro[2*s +: 2] = 2'h2;
      ex[17] = (s != 2'h3) || !c[7];
      mk[17] = 1'b1;
    end else if (s != 2'h3) begin
      ro[2*s +: 2] = 2'h3;
    end else if (!c[7]) begin
      ro = 6'h0F;
    end else begin
      mk[17] = 1'b1;
    end
    ex[13:8] = ro;
    // sensorless without pin config holds all three pins; otherwise only analog or digital inputs
    ex[16:14] = (!c[5] && !c[4]) ? 3'h7 : {ro[5], ro[3], ro[1]};
    wait_cycles(3);
    rd_reg(mids_pkg::ADDR_STATUS, rd);
    chk("status", {14'h0, ex}, {14'h0, rd[17:0] & mk});
    chk("pins", {19'h0, ex[17], ex[16:14], ro, gr},
        {19'h0, comparator_on & mk[17], pin_reserved, pin_roles, pin_ground_oe});
    rd_reg(mids_pkg::ADDR_CONFIG, rd);
    chk("config", {24'h0, c}, rd);
  endtask : chk_cfg

  initial begin
    logic [15:0] n0;
    logic [15:0] dn;
    logic [2:0]  lv;
    int          p0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    chk_cfg(mids_pkg::CFG_RESET);
    // refused writes and an unmapped read
    wr_reg(mids_pkg::ADDR_STATUS, 32'hFFFFFFFF, 4'hF);
    wr_reg(mids_pkg::ADDR_CONFIG, 32'h00000030, 4'hE);
    rd_reg(mids_pkg::ADDR_CONFIG, rd);
    chk("refused write", 32'h0, rd);
    rd_reg(4'hC, rd);
    chk("unmapped", 32'h0, rd);
    // every legal setting, select never changed under pin config with edge 00
    prev = 8'h00;
    for (int i = 0; i < 256; i++) begin
      cfg = i[7:0];
      if (!cfg[5] && (cfg[3:2] != 2'h0 || cfg[1:0] == 2'h3)) continue;
      if (prev[5] && prev[3:2] == 2'h0 && cfg[1:0] != prev[1:0])
        wr_reg(mids_pkg::ADDR_CONFIG, {24'h0, prev | 8'h04}, 4'h1);
      wr_reg(mids_pkg::ADDR_CONFIG, {24'h0, cfg}, 4'h1);
      chk_cfg(cfg);
      prev = cfg;
    end
    // capture events for each edge select and input select
    for (int e = 1; e < 4; e++) begin
      for (int s = 0; s < 4; s++) begin
        wr_reg(mids_pkg::ADDR_CONFIG, {24'h0, 4'h2, e[1:0], s[1:0]}, 4'h1);
        wait_cycles(3);
        rd_reg(mids_pkg::ADDR_EVENT, rd);
        n0 = rd[15:0];
        p0 = pulses;
        slow <= s[0];
        lv = 3'h0;
        for (int p = 0; p < 3; p++) begin
          lv[p] = 1'b1;
          level_req <= lv;
          wait_cycles(4);
          lv[p] = 1'b0;
          level_req <= lv;
          wait_cycles(4);
        end
        wait_cycles(4);
        rd_reg(mids_pkg::ADDR_EVENT, rd);
        dn = rd[15:0] - n0;
        p0 = pulses - p0;
        chk("event count", (s == 3) ? 32'h4 : (e == 3) ? 32'h2 : 32'h1, {16'h0, dn});
        chk("event pulses", (s == 3) ? 32'h4 : (e == 3) ? 32'h2 : 32'h1, p0);
      end
    end
    end_of_test();
  end
endmodule : tb_mids_top
